// ===== design/scc_cfg.svh
// Notes on behaviour
// - Reserved bits drop written values and always read back as zero.
// - Two-phase slew word: capacitor code bits 9:6, current code bits 5:0.
// - One capacitor code step is 1.85 pF of ramp capacitance.
// - One current code step is 0.25 uA of charging current.
// - One-phase slew word: capacitor bit 6, current bits 5:0, bits 15:7 reserved.
// - Two-phase time limit: bits 7:0 in 5 ns units (code counts one unit per 100 ns clock), bits 15:8 reserved.
// - One-phase time limit: 8-bit field in 5 ns units (code counts one unit per 100 ns clock), upper byte reserved.
// - On time-limit expiry the current source stops and ramp voltage holds.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_OFS_SLEW_2P      8'hd8
`define SCC_OFS_LIMIT_2P     8'hd9
`define SCC_OFS_SLEW_1P      8'hda
`define SCC_OFS_LIMIT_1P     8'hdb
`define SCC_CUR_LSB          0
`define SCC_CUR_MSB          5
`define SCC_CAP2_LSB         6
`define SCC_CAP2_MSB         9
`define SCC_CAP1_BIT         6
`define SCC_LIM_MSB          7
`define SCC_RST_SLEW         16'h0000
`define SCC_RST_LIMIT        16'h0000
`define SCC_TICK_NS          5
`define SCC_CLK_NS           100
`define SCC_TICK_CYC         ((`SCC_TICK_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CAP_FF           1850
`define SCC_CUR_NA           250
`endif

// ===== design/scc_pkg.sv
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_PH_ONE,
        SCC_PH_TWO,
        SCC_PH_OTHER
    } scc_phase_t;
    typedef enum logic [1:0] {
        SCC_IDLE,
        SCC_RAMP,
        SCC_HOLD
    } scc_ramp_t;
endpackage

// ===== design/scc_ramp_timer.sv
`timescale 1ns/10ps
`include "scc_cfg.svh"
module scc_ramp_timer #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Control
    input  wire logic             tick,
    input  wire logic             ramp_start,
    input  wire logic [CNT_W-1:0] limit,
    // Status
    output logic                  source_on,
    output logic                  ramp_hold
);
    scc_pkg::scc_ramp_t state;
    scc_pkg::scc_ramp_t next_state;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   next_count;

    always_comb begin
        next_state = state;
        next_count = count;
        if (ramp_start) begin
            next_count = '0;
            next_state = (limit == '0) ? scc_pkg::SCC_HOLD : scc_pkg::SCC_RAMP;
        end else begin
            case (state)
                scc_pkg::SCC_RAMP: begin
                    if (tick) begin
                        next_count = count + 1'b1;
                        // Stop source, freeze ramp once limit reached
                        if (count + 1'b1 >= limit) begin
                            next_state = scc_pkg::SCC_HOLD;
                        end
                    end
                end
                scc_pkg::SCC_HOLD: begin
                    next_state = scc_pkg::SCC_HOLD;
                end
                default: begin
                    next_state = scc_pkg::SCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= scc_pkg::SCC_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign source_on = (state == scc_pkg::SCC_RAMP);
    assign ramp_hold = (state == scc_pkg::SCC_HOLD);
endmodule

// ===== design/scc_regs.sv
`timescale 1ns/10ps
`include "scc_cfg.svh"
module scc_regs #(
    parameter int CUR_W = 6,
    parameter int CAP_W = 4,
    parameter int LIM_W = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Management command port
    input  wire logic [7:0]       cmd_code,
    input  wire logic             cmd_wr,
    input  wire logic             cmd_rd,
    input  wire logic [15:0]      cmd_wdata,
    output logic [15:0]           cmd_rdata,
    output logic                  cmd_ack,
    // Ramp control
    input  wire logic             single_phase,
    input  wire logic             cycle_start,
    // Ramp generator settings
    output logic [CUR_W-1:0]      ramp_current_code,
    output logic [CAP_W-1:0]      ramp_c_trim,
    output logic [LIM_W-1:0]      ramp_time_limit,
    output logic                  ramp_source_on,
    output logic                  ramp_hold
);
    ////////////////////////////////////////////////////////////////////////////
    // Register storage, only implemented bits kept
    logic [15:0] ramp_slew_two_phase;
    logic [15:0] ramp_limit_two_phase;
    logic [15:0] ramp_slew_one_phase;
    logic [15:0] ramp_limit_one_phase;
    logic [15:0] next_slew_2p;
    logic [15:0] next_limit_2p;
    logic [15:0] next_slew_1p;
    logic [15:0] next_limit_1p;
    logic [15:0] next_rdata;
    logic        next_ack;
    logic [2:0]  tick_div;
    logic [2:0]  next_tick_div;
    logic        tick;

    // Write masks: reserved bits never stored
    localparam logic [15:0] MASK_SLEW_2P  = 16'h03ff;
    localparam logic [15:0] MASK_SLEW_1P  = 16'h007f;
    localparam logic [15:0] MASK_LIMIT    = 16'h00ff;

    function automatic logic hit(input logic [7:0] code, input logic [7:0] ofs);
        hit = (code == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, whole 16-bit words
    always_comb begin
        next_slew_2p  = ramp_slew_two_phase;
        next_limit_2p = ramp_limit_two_phase;
        next_slew_1p  = ramp_slew_one_phase;
        next_limit_1p = ramp_limit_one_phase;
        next_rdata    = cmd_rdata;
        next_ack      = cmd_wr | cmd_rd;
        if (cmd_wr) begin
            if (hit(cmd_code, `SCC_OFS_SLEW_2P)) begin
                next_slew_2p = cmd_wdata & MASK_SLEW_2P;
            end
            if (hit(cmd_code, `SCC_OFS_LIMIT_2P)) begin
                next_limit_2p = cmd_wdata & MASK_LIMIT;
            end
            if (hit(cmd_code, `SCC_OFS_SLEW_1P)) begin
                next_slew_1p = cmd_wdata & MASK_SLEW_1P;
            end
            if (hit(cmd_code, `SCC_OFS_LIMIT_1P)) begin
                next_limit_1p = cmd_wdata & MASK_LIMIT;
            end
        end
        if (cmd_rd) begin
            // Unknown codes read zero
            case (cmd_code)
                `SCC_OFS_SLEW_2P:  next_rdata = ramp_slew_two_phase;
                `SCC_OFS_LIMIT_2P: next_rdata = ramp_limit_two_phase;
                `SCC_OFS_SLEW_1P:  next_rdata = ramp_slew_one_phase;
                `SCC_OFS_LIMIT_1P: next_rdata = ramp_limit_one_phase;
                default:           next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_slew_two_phase  <= `SCC_RST_SLEW;
            ramp_limit_two_phase <= `SCC_RST_LIMIT;
            ramp_slew_one_phase  <= `SCC_RST_SLEW;
            ramp_limit_one_phase <= `SCC_RST_LIMIT;
            cmd_rdata            <= 16'h0000;
            cmd_ack              <= 1'b0;
        end else begin
            ramp_slew_two_phase  <= next_slew_2p;
            ramp_limit_two_phase <= next_limit_2p;
            ramp_slew_one_phase  <= next_slew_1p;
            ramp_limit_one_phase <= next_limit_1p;
            cmd_rdata            <= next_rdata;
            cmd_ack              <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Select set by phase status; 1-phase cap bit lands in code LSB
    // Codes are raw: 1.85 pF and 0.25 uA per step in the analog ramp
    logic [CUR_W-1:0] next_current_code;
    logic [CAP_W-1:0] next_c_trim;
    logic [LIM_W-1:0] next_time_limit;

    always_comb begin
        if (single_phase) begin
            next_current_code = ramp_slew_one_phase[`SCC_CUR_MSB:`SCC_CUR_LSB];
            next_c_trim       = {{(CAP_W-1){1'b0}}, ramp_slew_one_phase[`SCC_CAP1_BIT]};
            next_time_limit   = ramp_limit_one_phase[`SCC_LIM_MSB:0];
        end else begin
            next_current_code = ramp_slew_two_phase[`SCC_CUR_MSB:`SCC_CUR_LSB];
            next_c_trim       = ramp_slew_two_phase[`SCC_CAP2_MSB:`SCC_CAP2_LSB];
            next_time_limit   = ramp_limit_two_phase[`SCC_LIM_MSB:0];
        end
    end

    // Registered so a phase change never glitches the analog codes
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_current_code <= '0;
            ramp_c_trim       <= '0;
            ramp_time_limit   <= '0;
        end else begin
            ramp_current_code <= next_current_code;
            ramp_c_trim       <= next_c_trim;
            ramp_time_limit   <= next_time_limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 5 ns tick; at 100 ns clock each cycle is one tick, a coarse limit
    always_comb begin
        next_tick_div = tick_div + 3'd1;
        if (tick_div >= 3'(`SCC_TICK_CYC - 1)) begin
            next_tick_div = 3'd0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_div <= 3'd0;
        end else begin
            tick_div <= next_tick_div;
        end
    end

    assign tick = (tick_div >= 3'(`SCC_TICK_CYC - 1));

    scc_ramp_timer #(
        .CNT_W (LIM_W)
    ) u_timer (
        .clk        (clk),
        .srst       (srst),
        .tick       (tick),
        .ramp_start (cycle_start),
        .limit      (ramp_time_limit),
        .source_on  (ramp_source_on),
        .ramp_hold  (ramp_hold)
    );
endmodule

// ===== bench/scc_asserts.sv
`timescale 1ns/10ps
module scc_asserts #(
    parameter int CUR_W = 6,
    parameter int CAP_W = 4,
    parameter int LIM_W = 8
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             srst,
    // Command port
    input wire logic [7:0]       cmd_code,
    input wire logic             cmd_wr,
    input wire logic             cmd_rd,
    input wire logic [15:0]      cmd_wdata,
    input wire logic [15:0]      cmd_rdata,
    input wire logic             cmd_ack,
    // Ramp side
    input wire logic             single_phase,
    input wire logic             cycle_start,
    input wire logic [CUR_W-1:0] ramp_current_code,
    input wire logic [CAP_W-1:0] ramp_c_trim,
    input wire logic [LIM_W-1:0] ramp_time_limit,
    input wire logic             ramp_source_on,
    input wire logic             ramp_hold
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_req;
        cmd_wr || cmd_rd;
    endsequence
    sequence s_stop;
        $fell(ramp_source_on) && !$past(cycle_start) && !$past(srst);
    endsequence
    property p_ack; s_req |=> cmd_ack; endproperty
    property p_rsv2; cmd_rd && cmd_code == 8'hd8 |=> cmd_rdata[15:10] == 6'h00; endproperty
    property p_rsv1; cmd_rd && cmd_code == 8'hda |=> cmd_rdata[15:7] == 9'h000; endproperty
    property p_rsvl; cmd_rd && cmd_code inside {8'hd9, 8'hdb} |=> cmd_rdata[15:8] == 8'h00;
    endproperty
    property p_unmap; cmd_rd && !(cmd_code inside {[8'hd8:8'hdb]}) |=> cmd_rdata == 16'h0000;
    endproperty
    property p_stop; s_stop |-> ramp_hold; endproperty
    property p_held; ramp_hold && !cycle_start |=> ramp_hold && !ramp_source_on; endproperty
    property p_sel1; single_phase && $past(single_phase) |-> ramp_c_trim[CAP_W-1:1] == '0;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_rsv2: assert property (p_rsv2) else $error("slew2 reserved");
    a_rsv1: assert property (p_rsv1) else $error("slew1 reserved");
    a_rsvl: assert property (p_rsvl) else $error("limit reserved");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_stop: assert property (p_stop) else $error("no hold at stop");
    a_held: assert property (p_held) else $error("hold lost");
    a_sel1: assert property (p_sel1) else $error("one-phase cap");
endmodule
bind scc_regs scc_asserts #(.CUR_W(CUR_W), .CAP_W(CAP_W), .LIM_W(LIM_W)) scc_asserts_inst (
    .clk(clk), .srst(srst), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .single_phase(single_phase), .cycle_start(cycle_start),
    .ramp_current_code(ramp_current_code), .ramp_c_trim(ramp_c_trim),
    .ramp_time_limit(ramp_time_limit), .ramp_source_on(ramp_source_on), .ramp_hold(ramp_hold));

// ===== bench/scc_host.sv
`timescale 1ns/10ps
module scc_host (
    // Clock
    input wire logic        clk,
    // Answer
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_ack,
    // Command
    output logic [7:0]      cmd_code,
    output logic            cmd_wr,
    output logic            cmd_rd,
    output logic [15:0]     cmd_wdata
);
    initial begin
        {cmd_code, cmd_wr, cmd_rd, cmd_wdata} = '0;
    end
    // Whole word per command, strobe up for the taking edge only
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic a);
        @(posedge clk);
        #1;
        {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {w, !w, c, d};
        @(posedge clk);
        #1;
        {cmd_wr, cmd_rd} = 2'h0;
        // Released lines must not keep a stale word
        {cmd_code, cmd_wdata} = ~{cmd_code, cmd_wdata};
        q = cmd_rdata;
        a = cmd_ack;
    endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic        clk, srst, single_phase, cycle_start, cmd_wr, cmd_rd, cmd_ack, a, src_on, hold;
    logic [7:0]  cmd_code, lim;
    logic [15:0] cmd_wdata, cmd_rdata, q;
    logic [5:0]  cur;
    logic [3:0]  cap;
    int          num_errors = 0, n_checks = 0, cyc = 0, cnt, len, tp, vmv, capc, curc;
    int          mdl[4];
    scc_regs scc_regs_inst (.clk(clk), .srst(srst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
        .single_phase(single_phase), .cycle_start(cycle_start), .ramp_current_code(cur),
        .ramp_c_trim(cap), .ramp_time_limit(lim), .ramp_source_on(src_on), .ramp_hold(hold));
    scc_host scc_host_inst (.clk(clk), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
        .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic int msk(input logic [7:0] c);
        case (c)
            8'hd8: return 'h3ff;
            8'hda: return 'h7f;
            8'hd9, 8'hdb: return 'hff;
            default: return 0;
        endcase
    endfunction
    task op(input logic w, input logic [7:0] c, input logic [15:0] d);
        scc_host_inst.xfer(w, c, d, q, a);
        chk("ack", 16'h1, {15'h0, a});
        if (w && msk(c) != 0) mdl[c-8'hd8] = d & msk(c);
        if (!w) chk("rdata", (msk(c) != 0) ? 16'(mdl[c-8'hd8]) : 16'h0, q);
    endtask
    task outs;
        repeat (2) @(posedge clk);
        #1;
        chk("cur", 16'(mdl[single_phase ? 2 : 0] & 'h3f), {10'h0, cur});
        chk("cap", single_phase ? 16'((mdl[2] >> 6) & 1) : 16'((mdl[0] >> 6) & 'hf),
            {12'h0, cap});
        chk("lim", 16'(mdl[single_phase ? 3 : 1]), {8'h0, lim});
    endtask
    task final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {srst, single_phase, cycle_start} = 3'b100;
        mdl = '{0, 0, 0, 0};
        void'($urandom(86));
        repeat (16) @(posedge clk);
        #1;
        srst = 0;
        for (int k = 0; k < 4; k++) op(0, 8'hd8 + k, 16'h0);
        $display("reset values done");
        repeat (40) begin
            op(1, 8'hd6 + 8'($urandom_range(0, 7)), 16'($urandom));
            single_phase = 1'($urandom);
            outs();
        end
        for (int k = 0; k < 8; k++) op(0, 8'hd6 + k, 16'h0);
        $display("register access done");
        // Limit 0 first: hold must come without any ramp
        for (int k = 0; k < 4; k++) begin
            single_phase = k[0];
            // Host sizing with 20 ns blanking; per-phase period 50 to 130 ns
            tp = $urandom_range(100, 130) / (single_phase ? 1 : 2);
            vmv = $urandom_range(20, 40) << $urandom_range(0, 1);
            capc = $urandom_range(0, single_phase ? 1 : 15);
            curc = vmv * (16 - capc) * 37 / (5 * (tp - 20));
            if (curc > 63) curc = 63;
            op(1, single_phase ? 8'hda : 8'hd8, 16'((capc << 6) | curc));
            len = (k < 2) ? 0 : 13 * (tp - 20) / 50;
            op(1, single_phase ? 8'hdb : 8'hd9, 16'(len));
            outs();
            cycle_start = 1;
            @(posedge clk);
            #1;
            cycle_start = 0;
            cnt = 0;
            repeat (40) begin
                if (src_on === 1'b1) cnt++;
                @(posedge clk);
                #1;
            end
            chk("ramp len", 16'(len), 16'(cnt));
            chk("hold", 16'h1, {15'h0, hold});
        end
        $display("ramp done");
        srst = 1;
        repeat (3) @(posedge clk);
        #1;
        srst = 0;
        mdl = '{0, 0, 0, 0};
        chk("hold rst", 16'h0, {14'h0, src_on, hold});
        outs();
        op(0, 8'hd9, 16'h0);
        $display("mid reset done");
        final_report();
    end
endmodule
